// *** ffd_host_model.sv ***
// host side: fault line pull-up, matrix line levels, fault pulse width watch
`timescale 1ns/1ns
module ffd_host_model (
  input wire logic clk, // clock
  input wire logic fault_oe, // fault pin pulls low
  input wire logic [2:0] row_out, // row drive
  input wire logic [2:0] row_oe, // row enable
  input wire logic [2:0] col_out, // column drive
  input wire logic [2:0] col_oe, // column enable
  output logic fault_line, // fault line level
  output logic [2:0] row_line, // row levels
  output logic [2:0] col_line, // column levels
  output logic [15:0] low_width // last low pulse length
);
  logic [15:0] run = 16'h0;
  // released lines settle at their pull level, never at the last driven value
  assign fault_line = fault_oe ? 1'b0 : 1'b1;
  assign row_line = (row_oe & row_out) | ~row_oe;
  assign col_line = col_oe & col_out;
  // measure each low pulse the way a polling host would see it
  initial low_width = 16'h0;
  always_ff @(posedge clk) begin
    run <= fault_line ? 16'h0 : run + 16'h1;
    if (fault_line && run != 16'h0) low_width <= run;
  end
endmodule : ffd_host_model

// *** ffd_pkg.sv ***
// constants, register map and types for the field fault diagnostics block
package ffd_pkg;
  // timing
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned WB_FILTER_MS = 20;
  localparam int unsigned WB_FILTER_CYC = WB_FILTER_MS * 1000000 / CLK_NS;
  localparam int unsigned SCAN_PERIOD_US = 1000;
  localparam int unsigned SCAN_SLOT_CYC = SCAN_PERIOD_US * 1000 / CLK_NS / 3;
  localparam int unsigned MIN_PULSE_NS = 1000;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] OFS_WB = 8'h00;
  localparam logic [7:0] OFS_PF = 8'h04;
  localparam logic [7:0] OFS_SF = 8'h08;
  localparam logic [7:0] OFS_PEN = 8'h0c;
  localparam logic [7:0] OFS_SEN = 8'h10;
  localparam logic [7:0] OFS_AUX = 8'h14;
  localparam logic [7:0] OFS_IND = 8'h18;
  localparam logic [7:0] OFS_CFG = 8'h1c;
  localparam logic [7:0] OFS_WBEN = 8'h20;
  localparam logic [7:0] OFS_IST = 8'h24;
  localparam logic [7:0] OFS_ICLR = 8'h28;
  localparam logic [7:0] OFS_IEN = 8'h2c;
  localparam logic [7:0] OFS_PINS = 8'h30;
  // primary fault flag bit positions
  localparam int unsigned PF_SLOW = 0;
  localparam int unsigned PF_SMISS = 1;
  localparam int unsigned PF_OT1 = 2;
  localparam int unsigned PF_OT2 = 3;
  localparam int unsigned PF_CRC = 4;
  localparam int unsigned PF_POR = 5;
  localparam int unsigned PF_WBG = 6;
  localparam int unsigned PF_SEC = 7;
  // aux output control bit positions
  localparam int unsigned AUX_DIR = 6;
  localparam int unsigned AUX_STK = 7;
  // interrupt event bit positions
  localparam int unsigned EV_WB = 0;
  localparam int unsigned EV_PF = 1;
  localparam int unsigned EV_CRC = 2;
  localparam int unsigned EV_PIN = 3;
  // reset values
  localparam logic [7:0] PEN_RST = 8'h30;
  localparam logic [7:0] SEN_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] IND_RST = 8'h00;
  localparam logic [7:0] WBEN_RST = 8'h00;
  localparam logic [7:0] PF_RST = 8'h20;
  // matrix scan slot, one row pulled low per slot
  typedef enum logic [1:0] {
    SCAN_ROW0 = 2'b00,
    SCAN_ROW1 = 2'b01,
    SCAN_ROW2 = 2'b10
  } ffd_scan_t;
endpackage : ffd_pkg

// *** ffd_props.sv ***
// concurrent checks on the fault pin and indicator matrix ports
`timescale 1ns/1ns
module ffd_props (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic supply_missing_in, // supply missing condition
  input wire logic field_fault_out, // fault pin drive value
  input wire logic field_fault_out_oe, // fault pin pulls low
  input wire logic [2:0] matrix_row_pin_out, // row drive values
  input wire logic [2:0] matrix_row_pin_oe, // row enables
  input wire logic [2:0] matrix_col_pin_out, // column drive values
  input wire logic [2:0] matrix_col_pin_oe // column enables
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // fault pin: por source is enabled out of reset, pulses never shorter than nine cycles
  AST_POR_PIN: assert property ($rose(presetn) |-> ##[0:3] field_fault_out_oe)
    else $error("fault pin not asserted after reset");
  AST_OPEN_DRAIN: assert property (field_fault_out_oe |-> !field_fault_out)
    else $error("fault pin driven high");
  AST_MIN_LOW: assert property ($rose(field_fault_out_oe) |=> field_fault_out_oe [*8])
    else $error("fault pin pulse too short");
  // matrix: one row at a time, so a column resistor never feeds two leds
  AST_ONE_ROW: assert property ($onehot0(matrix_row_pin_oe) || (&matrix_row_pin_oe))
    else $error("two matrix rows active");
  AST_ALL_PP: assert property (&matrix_row_pin_oe |-> &matrix_col_pin_oe)
    else $error("push-pull mode incomplete");
  AST_MATRIX_DRIVE: assert property (!(&matrix_row_pin_oe) |->
    ((matrix_row_pin_out & matrix_row_pin_oe) == 3'h0)
    && ((matrix_col_pin_out & matrix_col_pin_oe) == matrix_col_pin_oe))
    else $error("matrix pin drives wrong level");
  AST_SLOT_HOLD: assert property ($rose(matrix_row_pin_oe[1]) && !(&matrix_row_pin_oe)
    |=> matrix_row_pin_oe[1] [*8])
    else $error("scan slot too short");
  AST_SUPPLY_LED: assert property ((!supply_missing_in) [*6] ##0
    (matrix_row_pin_oe == 3'h4) |-> matrix_col_pin_oe[2])
    else $error("supply indicator dark");
endmodule : ffd_props
bind ffd_top ffd_props u_ffd_props (.pclk(pclk), .presetn(presetn),
  .supply_missing_in(supply_missing_in), .field_fault_out(field_fault_out),
  .field_fault_out_oe(field_fault_out_oe), .matrix_row_pin_out(matrix_row_pin_out),
  .matrix_row_pin_oe(matrix_row_pin_oe), .matrix_col_pin_out(matrix_col_pin_out),
  .matrix_col_pin_oe(matrix_col_pin_oe));

// *** ffd_sync.sv ***
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ns
module ffd_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous inputs
  input wire logic [W-1:0] q_rst, // unused reset image guard
  output logic [W-1:0] q // filtered synchronous outputs
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree = ~(s2 ^ s3);

  // s1 feeds only s2, so metastability never reaches logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s3 & agree) | (q & ~agree) | (q_rst & '0);
    end
  end
endmodule : ffd_sync

// *** ffd_top.sv ***
// field fault diagnostics: wire-break flags, fault flags, fault pin, indicator matrix
// Notes on behaviour
// - enabled wire-break trip filtered, then sets flag
// - reading wire-break register clears the flags it returned
// - chip select or latch low blocks wire-break flag setting
// - group flag is live OR of flags
// - select low: 3x3 open-drain indicator matrix
// - row 2 column 2 lit while supply present
// - indicator bits; lit ones 1kHz 33% duty
// - each column resistor feeds one indicator
// - select high: six push-pull level outputs
// - sticky: fault pin low when enabled flag set
// - primary enables gate only the fault pin
// - supply and overtemp flags latch until read
// - crc flag follows last mode 0/2 frame's crc result
// - pin-latch select: sticky or live fault pin
// - fault pin low pulse at least 1us
// - reset enables crc, por; pin non-sticky
// - mode 0/2 frames clear supply flags while config bit 0 is clear
// - valid mode 0/2 frame clears crc flag
`timescale 1ns/1ns
module ffd_top import ffd_pkg::*; #(
  parameter int unsigned WB_FILTER_CYCLES = WB_FILTER_CYC
) (
  input wire logic pclk, // bus clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic irq, // level interrupt, active high
  input wire logic [7:0] wire_break_trip, // wire-break comparators, high = current missing
  input wire logic supply_low_in, // field supply low condition
  input wire logic supply_missing_in, // field supply missing condition
  input wire logic overtemp_one_in, // overtemperature alarm one condition
  input wire logic overtemp_two_in, // overtemperature alarm two condition
  input wire logic [5:0] secondary_in, // secondary fault conditions
  input wire logic logic_chip_select_n, // logic chip select, active low
  input wire logic logic_latch_n, // logic latch, active low
  input wire logic frame_done, // serial frame ended, one-cycle pulse
  input wire logic [1:0] frame_mode, // serial mode of that frame
  input wire logic frame_crc_err, // frame had a crc error
  input wire logic field_fault_out_in, // fault line level
  output logic field_fault_out, // fault pin drive value
  output logic field_fault_out_oe, // fault pin pulls low
  input wire logic [2:0] matrix_row_pin_in, // row pin levels
  output logic [2:0] matrix_row_pin_out, // row pin drive values
  output logic [2:0] matrix_row_pin_oe, // row pin enables
  input wire logic [2:0] matrix_col_pin_in, // column pin levels
  output logic [2:0] matrix_col_pin_out, // column pin drive values
  output logic [2:0] matrix_col_pin_oe // column pin enables
);
  localparam int unsigned WB_W = $clog2(WB_FILTER_CYCLES + 1);
  localparam logic [WB_W-1:0] WB_LIM = WB_W'(WB_FILTER_CYCLES - 1);
  localparam logic [11:0] SLOT_LIM = 12'(SCAN_SLOT_CYC - 1);
  localparam logic [3:0] PULSE_LIM = 4'(MIN_PULSE_CYC - 1);
  localparam int unsigned SW = 27;

  // synchronised pins
  logic [SW-1:0] pin_s;
  ffd_sync #(.W(SW)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({matrix_row_pin_in, matrix_col_pin_in, field_fault_out_in, logic_chip_select_n,
        logic_latch_n, secondary_in, overtemp_two_in, overtemp_one_in, supply_missing_in,
        supply_low_in, wire_break_trip}),
    .q_rst('0),
    .q(pin_s)
  );
  wire [7:0] trip_s = pin_s[7:0];
  wire [3:0] cond_s = pin_s[11:8];
  wire [5:0] sec_s = pin_s[17:12];
  wire latch_s = pin_s[18];
  wire cs_s = pin_s[19];
  wire line_s = pin_s[20];
  wire [5:0] aux_pins_s = pin_s[26:21];

  // registers
  logic [7:0] wire_break_flags;
  logic [7:0] primary_latched;
  logic [5:0] secondary_fault_flags;
  logic [7:0] primary_fault_enable;
  logic [7:0] secondary_fault_enable;
  logic [7:0] aux_output_control;
  logic [7:0] indicator;
  logic supply_flag_clear_mode;
  logic [7:0] wb_enable;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;

  // apb decode; the answer comes one cycle after setup
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_wb = paddr == OFS_WB;
  wire hit_pf = paddr == OFS_PF;
  wire hit_sf = paddr == OFS_SF;
  wire hit_pen = paddr == OFS_PEN;
  wire hit_sen = paddr == OFS_SEN;
  wire hit_aux = paddr == OFS_AUX;
  wire hit_ind = paddr == OFS_IND;
  wire hit_cfg = paddr == OFS_CFG;
  wire hit_wben = paddr == OFS_WBEN;
  wire hit_ist = paddr == OFS_IST;
  wire hit_iclr = paddr == OFS_ICLR;
  wire hit_ien = paddr == OFS_IEN;
  wire hit_pins = paddr == OFS_PINS;
  wire mapped = hit_wb | hit_pf | hit_sf | hit_pen | hit_sen | hit_aux | hit_ind | hit_cfg |
                hit_wben | hit_ist | hit_iclr | hit_ien | hit_pins;

  // frame qualification: only modes 0 and 2 carry crc
  wire crc_mode = frame_done & ~frame_mode[0];
  wire frame_ok = crc_mode & ~frame_crc_err;
  wire frame_bad = crc_mode & frame_crc_err;
  logic crc_flag;

  // primary view: latched bits, crc, por, live group and secondary summary
  wire wire_break_group = |wire_break_flags;
  wire sec_any = |(secondary_fault_flags & secondary_fault_enable[5:0]);
  wire [7:0] primary_fault_flags = {sec_any, wire_break_group, primary_latched[PF_POR],
                                    crc_flag, primary_latched[3:0]};

  // read mux
  wire [7:0] rd_mux = hit_wb ? wire_break_flags :
                      hit_pf ? primary_fault_flags :
                      hit_sf ? {2'h0, secondary_fault_flags} :
                      hit_pen ? primary_fault_enable :
                      hit_sen ? secondary_fault_enable :
                      hit_aux ? aux_output_control :
                      hit_ind ? indicator :
                      hit_cfg ? {7'h00, supply_flag_clear_mode} :
                      hit_wben ? wb_enable :
                      hit_ist ? {4'h0, irq_status} :
                      hit_ien ? {4'h0, irq_enable} :
                      hit_pins ? {2'h0, aux_pins_s} : 8'h00;

  // bus answer; prdata holds the snapshot that a read-clear removes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h000000, pwrite ? 8'h00 : rd_mux};
      end
    end
  end

  // only bits that software actually saw are cleared, so a flag set
  // between setup and access is not lost
  wire [7:0] seen = prdata[7:0];
  wire rd_wb = rd & hit_wb;
  wire rd_pf = rd & hit_pf;
  wire rd_sf = rd & hit_sf;

  // wire-break filters, one per channel
  wire freeze = ~cs_s | ~latch_s;
  logic [7:0] wb_pass;
  for (genvar i = 0; i < 8; i++) begin : g_wb
    logic [WB_W-1:0] cnt;
    // any gap in the trip restarts the 20 ms window
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= '0;
      end else if (!(wb_enable[i] & trip_s[i])) begin
        cnt <= '0;
      end else if (cnt != WB_LIM) begin
        cnt <= cnt + 1'b1;
      end
    end
    assign wb_pass[i] = cnt == WB_LIM;
  end
  wire [7:0] wb_set = wb_pass & {8{~freeze}};
  wire [7:0] next_wire_break_flags = (wire_break_flags & ~(rd_wb ? seen : 8'h00)) | wb_set;

  // primary latched bits: supply low, missing, overtemp one and two, por
  wire supply_clr = crc_mode & ~supply_flag_clear_mode;
  wire [7:0] pf_clr = (rd_pf ? seen : 8'h00) | {6'h00, {2{supply_clr}}};
  wire [7:0] pf_set = {4'h0, cond_s};
  wire [7:0] next_primary_latched = (primary_latched & ~pf_clr) | pf_set;
  wire [5:0] next_secondary = (secondary_fault_flags & ~(rd_sf ? seen[5:0] : 6'h00)) | sec_s;

  // flag registers; a set always wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_break_flags <= 8'h00;
      primary_latched <= PF_RST;
      secondary_fault_flags <= 6'h00;
      crc_flag <= 1'b0;
    end else begin
      wire_break_flags <= next_wire_break_flags;
      primary_latched <= next_primary_latched & 8'h2f;
      secondary_fault_flags <= next_secondary;
      if (frame_bad) begin
        crc_flag <= 1'b1;
      end else if (frame_ok) begin
        crc_flag <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_fault_enable <= PEN_RST;
      secondary_fault_enable <= SEN_RST;
      aux_output_control <= AUX_RST;
      indicator <= IND_RST;
      supply_flag_clear_mode <= 1'b0;
      wb_enable <= WBEN_RST;
      irq_enable <= 4'h0;
    end else if (wr) begin
      if (hit_pen) primary_fault_enable <= pwdata[7:0];
      if (hit_sen) secondary_fault_enable <= pwdata[7:0];
      if (hit_aux) aux_output_control <= pwdata[7:0];
      if (hit_ind) indicator <= pwdata[7:0];
      if (hit_cfg) supply_flag_clear_mode <= pwdata[0];
      if (hit_wben) wb_enable <= pwdata[7:0];
      if (hit_ien) irq_enable <= pwdata[3:0];
    end
  end

  // fault pin sources: sticky follows flags, non-sticky follows live supply, overtemp and secondary conditions
  wire pin_latch_select = aux_output_control[AUX_STK];
  wire [7:0] live_src = {|(sec_s & secondary_fault_enable[5:0]), wire_break_group,
                         primary_latched[PF_POR], crc_flag, cond_s};
  wire [7:0] pin_src = pin_latch_select ? primary_fault_flags : live_src;
  wire fault_req = |(pin_src & primary_fault_enable);
  logic [3:0] pulse_cnt;
  wire fault_start = fault_req & ~field_fault_out_oe;
  wire next_fault_oe = fault_req | (pulse_cnt != 4'h0);

  // stretch each assertion so the host cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= 4'h0;
      field_fault_out_oe <= 1'b0;
      field_fault_out <= 1'b0;
    end else begin
      field_fault_out_oe <= next_fault_oe;
      field_fault_out <= 1'b0;
      if (fault_start) begin
        pulse_cnt <= PULSE_LIM;
      end else if (pulse_cnt != 4'h0) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end

  // interrupt events
  wire [3:0] ev = {fault_start, frame_bad, |(pf_set & ~primary_latched),
                   |(wb_set & ~wire_break_flags)};
  wire [3:0] iclr = (wr & hit_iclr) ? pwdata[3:0] : 4'h0;
  wire next_irq = |(irq_status & irq_enable);
  logic line_seen;

  // status is sticky; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
      irq <= 1'b0;
      line_seen <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~iclr) | ev;
      irq <= next_irq;
      line_seen <= line_s;
    end
  end

  // matrix scan: one row low per slot keeps each column resistor on one led
  ffd_scan_t scan;
  ffd_scan_t next_scan;
  logic [11:0] slot_cnt;
  wire slot_end = slot_cnt == SLOT_LIM;
  always_comb begin
    unique case (scan)
      SCAN_ROW0: next_scan = SCAN_ROW1;
      SCAN_ROW1: next_scan = SCAN_ROW2;
      SCAN_ROW2: next_scan = SCAN_ROW0;
      default: next_scan = SCAN_ROW0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan <= SCAN_ROW0;
      slot_cnt <= 12'h000;
    end else begin
      slot_cnt <= slot_end ? 12'h000 : slot_cnt + 1'b1;
      if (slot_end) begin
        scan <= next_scan;
      end
    end
  end

  // position r*3+c, with the supply indicator last
  wire supply_ok = ~cond_s[PF_SMISS];
  wire [8:0] lit = {supply_ok, indicator};
  wire [1:0] row_idx = scan;
  wire [2:0] row_lit = row_idx == 2'd0 ? lit[2:0] : row_idx == 2'd1 ? lit[5:3] : lit[8:6];
  wire [2:0] row_sel = 3'h1 << row_idx;
  wire dir = aux_output_control[AUX_DIR];

  // pins: matrix open-drain, or push-pull levels with scanning ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_row_pin_out <= 3'h0;
      matrix_row_pin_oe <= 3'h0;
      matrix_col_pin_out <= 3'h0;
      matrix_col_pin_oe <= 3'h0;
    end else if (dir) begin
      matrix_row_pin_out <= aux_output_control[2:0];
      matrix_row_pin_oe <= 3'h7;
      matrix_col_pin_out <= aux_output_control[5:3];
      matrix_col_pin_oe <= 3'h7;
    end else begin
      matrix_row_pin_out <= 3'h0;
      matrix_row_pin_oe <= (|row_lit) ? row_sel : 3'h0;
      matrix_col_pin_out <= 3'h7;
      matrix_col_pin_oe <= row_lit;
    end
  end
endmodule : ffd_top

// *** test_field_fault_diagnostics.sv ***
// self-checking bench for the field fault diagnostics block
`timescale 1ns/1ns
module test_field_fault_diagnostics import ffd_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] trip = 8'h00;
  logic s_low = 1'b0;
  logic s_miss = 1'b0;
  logic latch_n = 1'b1;
  logic cs_n = 1'b1;
  logic f_done = 1'b0;
  logic [1:0] f_mode = 2'h0;
  logic f_err = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, ffo, ffo_oe, f_line, err;
  logic [2:0] r_out, r_oe, c_out, c_oe, r_line, c_line;
  logic [15:0] low_w;
  int n_errors = 0;
  int checks_done = 0;
  // short wire-break filter keeps the run brief
  ffd_top #(.WB_FILTER_CYCLES(20)) u_ffd_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .wire_break_trip(trip),
    .supply_low_in(s_low), .supply_missing_in(s_miss), .overtemp_one_in(1'b0),
    .overtemp_two_in(1'b0), .secondary_in(6'h00), .logic_chip_select_n(cs_n),
    .logic_latch_n(latch_n), .frame_done(f_done), .frame_mode(f_mode),
    .frame_crc_err(f_err), .field_fault_out_in(f_line), .field_fault_out(ffo),
    .field_fault_out_oe(ffo_oe), .matrix_row_pin_in(r_line), .matrix_row_pin_out(r_out),
    .matrix_row_pin_oe(r_oe), .matrix_col_pin_in(c_line), .matrix_col_pin_out(c_out),
    .matrix_col_pin_oe(c_oe));
  ffd_host_model u_ffd_host_model (.clk(pclk), .fault_oe(ffo_oe), .row_out(r_out),
    .row_oe(r_oe), .col_out(c_out), .col_oe(c_oe), .fault_line(f_line), .row_line(r_line),
    .col_line(c_line), .low_width(low_w));
  // 10 MHz clock
  initial forever #50 pclk = ~pclk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // let registered outputs land, then look at them mid-cycle
  task automatic settle;
    cyc(2);
    @(negedge pclk);
  endtask : settle
  // one apb transfer; pready and read data are taken at the rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      end_of_test();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic pulse_low(input int n);
    @(posedge pclk);
    s_low <= 1'b1;
    cyc(n);
    s_low <= 1'b0;
  endtask : pulse_low
  task automatic frame(input logic [1:0] m, input logic e);
    @(posedge pclk);
    f_done <= 1'b1;
    f_mode <= m;
    f_err <= e;
    @(posedge pclk);
    f_done <= 1'b0;
    cyc(4);
  endtask : frame
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(4);
    presetn <= 1'b1;
    settle();
    chk("pin_por", 1, ffo_oe);
    rd("pen", OFS_PEN, 32'h30);
    rd("aux", OFS_AUX, 32'h00);
    rd("unmapped", 8'h3c, 32'h00);
    chk("slverr", 1, err);
    rd("pf_por", OFS_PF, 32'h20);
    rd("pf_clear", OFS_PF, 32'h00);
    cyc(15);
    settle();
    chk("pin_off", 0, ffo_oe);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wb;
    wr(OFS_WBEN, 32'h05);
    latch_n <= 1'b0;
    trip <= 8'h07;
    cyc(60);
    rd("wb_frozen", OFS_WB, 32'h00);
    latch_n <= 1'b1;
    cs_n <= 1'b0;
    cyc(40);
    rd("wb_frozen_cs", OFS_WB, 32'h00);
    cs_n <= 1'b1;
    cyc(40);
    trip <= 8'h00;
    cyc(6);
    rd("group_set", OFS_PF, 32'h40);
    rd("group_kept", OFS_PF, 32'h40);
    rd("wb_flags", OFS_WB, 32'h05);
    rd("wb_clear", OFS_WB, 32'h00);
    rd("group_clear", OFS_PF, 32'h00);
    $display("test wire break done");
  endtask : t_wb
  task automatic t_pin;
    wr(OFS_PEN, 32'h01);
    pulse_low(3);
    cyc(30);
    chk("pulse_width", 1, low_w >= 16'd10);
    settle();
    chk("pin_live", 0, ffo_oe);
    rd("low_latched", OFS_PF, 32'h01);
    rd("low_cleared", OFS_PF, 32'h00);
    wr(OFS_AUX, 32'h80);
    pulse_low(3);
    cyc(30);
    settle();
    chk("pin_sticky", 1, ffo_oe);
    rd("low_sticky", OFS_PF, 32'h01);
    cyc(15);
    settle();
    chk("pin_sticky_off", 0, ffo_oe);
    wr(OFS_PEN, 32'h00);
    s_miss <= 1'b1;
    cyc(8);
    s_miss <= 1'b0;
    settle();
    chk("pin_masked", 0, ffo_oe);
    rd("miss_flag", OFS_PF, 32'h02);
    wr(OFS_AUX, 32'h00);
    $display("test fault pin done");
  endtask : t_pin
  task automatic t_frame;
    wr(OFS_PEN, 32'h10);
    wr(OFS_CFG, 32'h00);
    frame(2'h0, 1'b1);
    rd("crc_set", OFS_PF, 32'h10);
    settle();
    chk("pin_crc", 1, ffo_oe);
    rd("crc_kept", OFS_PF, 32'h10);
    frame(2'h1, 1'b0);
    rd("crc_mode1", OFS_PF, 32'h10);
    frame(2'h2, 1'b0);
    rd("crc_clear", OFS_PF, 32'h00);
    frame(2'h3, 1'b1);
    rd("crc_mode3", OFS_PF, 32'h00);
    pulse_low(3);
    cyc(6);
    frame(2'h2, 1'b0);
    rd("frame_clears", OFS_PF, 32'h00);
    wr(OFS_CFG, 32'h01);
    pulse_low(3);
    cyc(6);
    frame(2'h0, 1'b0);
    rd("frame_keeps", OFS_PF, 32'h01);
    $display("test frames done");
  endtask : t_frame
  task automatic t_irq;
    wr(OFS_PEN, 32'h00);
    wr(OFS_ICLR, 32'h0f);
    wr(OFS_IEN, 32'h04);
    frame(2'h0, 1'b1);
    settle();
    chk("irq_set", 1, irq);
    rd("irq_status", OFS_IST, 32'h04);
    wr(OFS_IEN, 32'h00);
    settle();
    chk("irq_masked", 0, irq);
    wr(OFS_IEN, 32'h04);
    settle();
    chk("irq_again", 1, irq);
    wr(OFS_ICLR, 32'h04);
    settle();
    chk("irq_cleared", 0, irq);
    rd("status_clear", OFS_IST, 32'h00);
    wr(8'h3c, 32'hff);
    chk("wr_slverr", 1, err);
    frame(2'h0, 1'b0);
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_matrix;
    int k;
    wr(OFS_IND, 32'h08);
    wr(OFS_AUX, 32'h00);
    k = 0;
    // leave a row-1 slot already under way, so counting starts at a slot edge
    while (r_oe === 3'h2 && k < 12000) begin
      @(negedge pclk);
      k++;
    end
    k = 0;
    while (r_oe !== 3'h2 && k < 12000) begin
      @(negedge pclk);
      k++;
    end
    chk("row1_found", 1, k < 12000);
    chk("row1_col", 3'h1, c_oe);
    chk("row1_low", 3'h0, r_out & r_oe);
    k = 0;
    for (int i = 0; i < 9999; i++) begin
      @(negedge pclk);
      if (c_oe[0] === 1'b1) k++;
    end
    chk("duty", 3333, k);
    wr(OFS_AUX, 32'h6d);
    cyc(8);
    settle();
    chk("pp_oe", 6'h3f, {c_oe, r_oe});
    chk("pp_lvl", 6'h2d, {c_out, r_out});
    rd("pin_levels", OFS_PINS, 32'h2d);
    $display("test matrix done");
  endtask : t_matrix
  // main sequence, second reset in mid-run at the end
  initial begin
    t_reset();
    t_wb();
    t_pin();
    t_frame();
    t_irq();
    t_matrix();
    t_reset();
    end_of_test();
  end
endmodule : test_field_fault_diagnostics
